// ==== common/vdf_params.svh ====
// constants for the voice/data frame timing block
`ifndef VDF_PARAMS_SVH
`define VDF_PARAMS_SVH

// ----------------------------------------------------------------
// clock rates
// ----------------------------------------------------------------
`define VDF_CORE_HZ 100000000
`define VDF_XTAL_HZ 4096000
`define VDF_TRANSPORT_HZ 2048000
`define VDF_DATA_CLK_HZ 128000
`define VDF_FRAME_HZ 8000

// ----------------------------------------------------------------
// frame counter layout
// ----------------------------------------------------------------
`define VDF_CNT_W 8
`define VDF_CNT_ZERO 8'h00
`define VDF_CNT_ONE 8'h01
`define VDF_MASTER_LAST 8'hff
`define VDF_SLAVE_LAST 8'h0f
`define VDF_WINDOW_LEN 8'h08

// ----------------------------------------------------------------
// data clock divider: toggle after 16 crystal edges
// ----------------------------------------------------------------
`define VDF_DIV_W 4
`define VDF_DIV_ZERO 4'h0
`define VDF_DIV_LAST 4'hf

// ----------------------------------------------------------------
// voice word and ringer cadence
// ----------------------------------------------------------------
`define VDF_WORD_W 8
`define VDF_WORD_MSB 7
`define VDF_BIT_IDX_W 3
`define VDF_BIT_IDX_ZERO 3'h0
`define VDF_BIT_IDX_LAST 3'h7
`define VDF_FIFO_DEPTH 8
`define VDF_RING_W 8
`define VDF_RING_ZERO 8'h00
`define VDF_RING_HALF_FRAMES 8'h40

`endif

// ==== common/vdf_pkg.sv ====
// types shared by the voice/data frame timing block
package vdf_pkg;

  // which end of the loop this timing logic serves
  typedef enum logic {
    VDF_MASTER,
    VDF_SLAVE
  } vdf_role_type;

endpackage

// ==== verilog/vdf_fifo.sv ====
// word fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module vdf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import vdf_pkg::*;

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // word storage
  logic [AW-1:0] wr_ptr_ff;       // next slot to write
  logic [AW-1:0] rd_ptr_ff;       // head slot
  logic [CW-1:0] count_ff;        // words held
  logic [CW-1:0] nxt_count;       // words held next cycle
  logic in_ready_ff;              // registered not-full
  logic out_valid_ff;             // registered not-empty
  logic push;                     // word accepted
  logic pop;                      // word drained

  assign push = in_valid && in_ready_ff;
  assign pop = out_valid_ff && out_ready;
  assign in_ready = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data = mem[rd_ptr_ff];

  // next fill level
  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + CW'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - CW'(1);
    end
  end

  // write side: storage is not reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // pointers, level and the two handshake flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      in_ready_ff <= 1'b0;
      out_valid_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + AW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + AW'(1);
      end
      count_ff <= nxt_count;
      in_ready_ff <= (nxt_count != CNT_FULL);
      out_valid_ff <= (nxt_count != '0);
    end
  end

endmodule
`default_nettype wire

// ==== verilog/vdf_frame_timing.sv ====
// frame timing, voice serialiser and loose bit transfer for a voice/data loop modem
// How it works
// - buffer crystal clock, halve it for transport
// - counter chain makes one sync per frame
// - frame sync enables voice and data exchange
// - one 8-bit voice word each way per frame
// - sync high for exactly eight periods of the active bit clock (transport in master, data clock in slave)
// - launch on rise, capture on fall, inside sync
// - loose bits move on sync rise and fall
// - converter data output disable gives high impedance
// - transceiver data output select gives high impedance
// - slave role derives all clocks from crystal
// - slave transmit sync acts as master sync
// - slave receive sync is inverse of transmit
// - slave data clock moves voice bits
// - ringing toggles buzzer at cadence rate in slave role
// - frame carries voice, signalling and data bits
`include "vdf_params.svh"
`timescale 1ns/1ns
`default_nettype none
module vdf_frame_timing (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire vdf_pkg::vdf_role_type ROLE,
  input wire logic XTAL_IN,
  input wire logic RING_ACTIVE,
  input wire logic CONV_OUT_DISABLE,
  input wire logic DATA_OUT_SELECT,
  input wire logic VOICE_IN,
  input wire logic DATA_BIT_IN,
  input wire logic SIG_BIT_IN,
  input wire logic [7:0] TX_WORD,
  input wire logic TX_VALID,
  output logic TX_READY,
  input wire logic TX_DATA_BIT,
  input wire logic TX_SIG_BIT,
  output logic XTAL_BUF,
  output logic TRANSPORT_CLK,
  output logic MASTER_FRAME_SYNC,
  output logic SLAVE_TRANSMIT_SYNC,
  output logic SLAVE_RECEIVE_SYNC,
  output logic DATA_CLK,
  output logic CLOCK_MODE_SELECT,
  output logic VOICE_OUT,
  output logic DATA_BIT_OUT,
  output logic DATA_BIT_OE,
  output logic SIG_BIT_OUT,
  output logic CONV_DATA_OUT,
  output logic CONV_DATA_OE,
  output logic [7:0] RX_WORD,
  output logic RX_VALID,
  output logic RX_DATA_BIT,
  output logic RX_SIG_BIT,
  output logic BUZZER,
  output logic UNDERRUN
);
  import vdf_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;  // first reset stage
  logic rst_n;        // released reset used everywhere

  // reset enters asynchronously, leaves through two flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 8;
  logic [NPIN-1:0] pin_raw;      // raw pin levels
  logic [NPIN-1:0] pin_meta_ff;  // first stage, read only by second
  logic [NPIN-1:0] pin_ff;       // safe copies
  logic xtal_last_ff;            // previous crystal level for edge detect

  assign pin_raw = {ROLE, XTAL_IN, RING_ACTIVE, CONV_OUT_DISABLE, DATA_OUT_SELECT, VOICE_IN, DATA_BIT_IN, SIG_BIT_IN};

  // two flops per pin, one pin per generate step
  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
        pin_meta_ff[g] <= 1'b0;
        pin_ff[g] <= 1'b0;
      end else begin
        pin_meta_ff[g] <= pin_raw[g];
        pin_ff[g] <= pin_meta_ff[g];
      end
    end
  end

  logic role_slave;  // slave role selected
  logic xtal_s;      // crystal level
  logic ring_s;      // exchange ringing
  logic conv_dis_s;  // converter output disable
  logic data_sel_s;  // transceiver data output select
  logic voice_in_s;  // serial voice from codec
  logic data_in_s;   // data bit from transceiver
  logic sig_in_s;    // signalling bit in

  assign role_slave = (pin_ff[7] == VDF_SLAVE);
  assign xtal_s = pin_ff[6];
  assign ring_s = pin_ff[5];
  assign conv_dis_s = pin_ff[4];
  assign data_sel_s = pin_ff[3];
  assign voice_in_s = pin_ff[2];
  assign data_in_s = pin_ff[1];
  assign sig_in_s = pin_ff[0];

  // ----------------------------------------------------------------
  // crystal buffer, transport halver, data clock divider
  // ----------------------------------------------------------------
  logic xtal_rise;                   // crystal rising edge seen
  logic tclk_ff;                     // halved crystal clock
  logic [`VDF_DIV_W-1:0] div_ff;     // crystal edges for data clock
  logic dclk_ff;                     // slave data clock
  logic bit_rise;                    // launch edge of active bit clock
  logic bit_fall;                    // capture edge of active bit clock

  assign xtal_rise = xtal_s && !xtal_last_ff;
  assign bit_rise = xtal_rise && (role_slave ? (!dclk_ff && div_ff == `VDF_DIV_LAST) : !tclk_ff);
  assign bit_fall = xtal_rise && (role_slave ? (dclk_ff && div_ff == `VDF_DIV_LAST) : tclk_ff);

  // buffered crystal and divide by two
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      xtal_last_ff <= 1'b0;
      tclk_ff <= 1'b0;
    end else begin
      xtal_last_ff <= xtal_s;
      if (xtal_rise) begin
        tclk_ff <= !tclk_ff;
      end
    end
  end

  // slave data clock: crystal divided by 32
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= `VDF_DIV_ZERO;
      dclk_ff <= 1'b0;
    end else if (xtal_rise) begin
      div_ff <= div_ff + `VDF_DIV_W'(1);
      if (div_ff == `VDF_DIV_LAST) begin
        dclk_ff <= !dclk_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // frame counter and syncs
  // ----------------------------------------------------------------
  logic [`VDF_CNT_W-1:0] cnt_ff;    // bit clocks into the frame
  logic [`VDF_CNT_W-1:0] nxt_cnt;   // count after this bit clock
  logic win_ff;                     // transmit window, the frame sync
  logic nxt_win;                    // window after this bit clock
  logic sync_rise;                  // frame sync goes high now
  logic sync_fall;                  // frame sync goes low now

  // window decode shared by the counter and the assertions
  function automatic logic in_window(input logic [`VDF_CNT_W-1:0] c);
    in_window = (c < `VDF_WINDOW_LEN);
  endfunction

  always_comb begin
    nxt_cnt = cnt_ff + `VDF_CNT_ONE;
    if (cnt_ff == (role_slave ? `VDF_SLAVE_LAST : `VDF_MASTER_LAST)) begin
      nxt_cnt = `VDF_CNT_ZERO;
    end
  end

  assign nxt_win = in_window(nxt_cnt);
  assign sync_rise = bit_rise && nxt_win && !win_ff;
  assign sync_fall = bit_rise && !nxt_win && win_ff;

  // counter chain clocked by the active bit clock
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= `VDF_MASTER_LAST;
      win_ff <= 1'b0;
    end else if (bit_rise) begin
      cnt_ff <= nxt_cnt;
      win_ff <= nxt_win;
    end
  end

  // clock and sync pins, each straight from a flop
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      XTAL_BUF <= 1'b0;
      TRANSPORT_CLK <= 1'b0;
      DATA_CLK <= 1'b0;
      MASTER_FRAME_SYNC <= 1'b0;
      SLAVE_TRANSMIT_SYNC <= 1'b0;
      SLAVE_RECEIVE_SYNC <= 1'b0;
      CLOCK_MODE_SELECT <= 1'b0;
    end else begin
      XTAL_BUF <= xtal_s;
      TRANSPORT_CLK <= tclk_ff;
      DATA_CLK <= dclk_ff;
      MASTER_FRAME_SYNC <= !role_slave && win_ff;
      SLAVE_TRANSMIT_SYNC <= role_slave && win_ff;
      SLAVE_RECEIVE_SYNC <= role_slave && !win_ff;
      CLOCK_MODE_SELECT <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outgoing voice: fifo then serialiser
  // ----------------------------------------------------------------
  logic [`VDF_WORD_W-1:0] head_word;  // word at the fifo head
  logic head_valid;                   // fifo holds a word
  logic take_word;                    // pop at window start
  logic [`VDF_WORD_W-1:0] tx_sh_ff;   // outgoing shift register

  assign take_word = sync_rise && head_valid;

  vdf_fifo #(
    .WIDTH(`VDF_WORD_W),
    .DEPTH(`VDF_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .in_data(TX_WORD),
    .in_valid(TX_VALID),
    .in_ready(TX_READY),
    .out_data(head_word),
    .out_valid(head_valid),
    .out_ready(take_word)
  );

  // launch one bit per rising bit clock inside the window
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_ff <= '0;
      VOICE_OUT <= 1'b0;
      UNDERRUN <= 1'b0;
    end else if (bit_rise) begin
      UNDERRUN <= sync_rise && !head_valid;  // idle word sent
      if (sync_rise) begin
        tx_sh_ff <= head_valid ? {head_word[`VDF_WORD_MSB-1:0], 1'b0} : '0;
        VOICE_OUT <= head_valid && head_word[`VDF_WORD_MSB];
      end else if (nxt_win) begin
        tx_sh_ff <= {tx_sh_ff[`VDF_WORD_MSB-1:0], 1'b0};
        VOICE_OUT <= tx_sh_ff[`VDF_WORD_MSB];
      end else begin
        VOICE_OUT <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // incoming voice: capture on falling bit clock
  // ----------------------------------------------------------------
  logic cap_win;                            // capture enable sync
  logic [`VDF_WORD_W-1:0] rx_sh_ff;         // incoming shift register
  logic [`VDF_BIT_IDX_W-1:0] rx_idx_ff;     // bits captured so far

  // master shares one sync, slave captures under the receive sync
  assign cap_win = role_slave ? !win_ff : win_ff;

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_ff <= '0;
      rx_idx_ff <= `VDF_BIT_IDX_ZERO;
      RX_WORD <= '0;
      RX_VALID <= 1'b0;
    end else begin
      RX_VALID <= 1'b0;
      if (bit_fall && cap_win) begin
        rx_sh_ff <= {rx_sh_ff[`VDF_WORD_MSB-1:0], voice_in_s};
        rx_idx_ff <= rx_idx_ff + `VDF_BIT_IDX_W'(1);
        if (rx_idx_ff == `VDF_BIT_IDX_LAST) begin
          RX_WORD <= {rx_sh_ff[`VDF_WORD_MSB-1:0], voice_in_s};
          RX_VALID <= 1'b1;
        end
      end else if (!cap_win) begin
        rx_idx_ff <= `VDF_BIT_IDX_ZERO;  // realign each frame
      end
    end
  end

  // ----------------------------------------------------------------
  // data and signalling bits
  // ----------------------------------------------------------------
  // transceiver side moves on the sync rising edge
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      DATA_BIT_OUT <= 1'b0;
      SIG_BIT_OUT <= 1'b0;
      RX_DATA_BIT <= 1'b0;
      RX_SIG_BIT <= 1'b0;
    end else if (sync_rise) begin
      DATA_BIT_OUT <= TX_DATA_BIT;
      SIG_BIT_OUT <= TX_SIG_BIT;
      RX_DATA_BIT <= data_in_s;
      RX_SIG_BIT <= sig_in_s;
    end
  end

  // converter side moves on the sync falling edge
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CONV_DATA_OUT <= 1'b0;
    end else if (sync_fall) begin
      CONV_DATA_OUT <= RX_DATA_BIT;
    end
  end

  // output enables: high while driving
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      DATA_BIT_OE <= 1'b0;
      CONV_DATA_OE <= 1'b0;
    end else begin
      DATA_BIT_OE <= !data_sel_s;
      CONV_DATA_OE <= !conv_dis_s;
    end
  end

  // ----------------------------------------------------------------
  // ringer cadence
  // ----------------------------------------------------------------
  logic [`VDF_RING_W-1:0] ring_cnt_ff;  // frames in this half cycle

  // buzzer toggles every cadence half period while ringing in slave role
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ring_cnt_ff <= `VDF_RING_ZERO;
      BUZZER <= 1'b0;
    end else if (!(ring_s && role_slave)) begin
      ring_cnt_ff <= `VDF_RING_ZERO;
      BUZZER <= 1'b0;
    end else if (sync_rise) begin
      if (ring_cnt_ff == `VDF_RING_HALF_FRAMES - `VDF_RING_W'(1)) begin
        ring_cnt_ff <= `VDF_RING_ZERO;
        BUZZER <= !BUZZER;
      end else begin
        ring_cnt_ff <= ring_cnt_ff + `VDF_RING_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n);

  logic [`VDF_CNT_W-1:0] hi_len_ff;  // launch edges seen while the sync is high

  // helper: measures the high phase apart from the frame counter
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      hi_len_ff <= `VDF_CNT_ZERO;
    end else if (!win_ff) begin
      hi_len_ff <= `VDF_CNT_ZERO;  // opening edge is not counted
    end else if (bit_rise) begin
      hi_len_ff <= hi_len_ff + `VDF_CNT_ONE;
    end
  end

  tclk_halves_a: assert property ($changed(tclk_ff) |-> $past(xtal_rise))
    else $error("transport clock moved without a crystal edge");
  frame_wrap_a: assert property ((bit_rise && !role_slave && cnt_ff == `VDF_MASTER_LAST) |=> cnt_ff == `VDF_CNT_ZERO)
    else $error("master frame did not wrap after 256 clocks");
  sync_window_a: assert property (sync_fall |-> (hi_len_ff == `VDF_WINDOW_LEN - `VDF_CNT_ONE) && !in_window(nxt_cnt))
    else $error("frame sync not high for exactly eight clocks");
  sync_pin_a: assert property (win_ff && !role_slave && $stable(role_slave) |=> MASTER_FRAME_SYNC)
    else $error("master sync pin lags the window");
  pop_start_a: assert property (take_word |=> VOICE_OUT == $past(head_word[`VDF_WORD_MSB]))
    else $error("popped word did not launch its top bit");
  launch_edge_a: assert property ($changed(VOICE_OUT) |-> $past(bit_rise))
    else $error("voice bit launched off the rising edge");
  capture_edge_a: assert property (RX_VALID |-> $past(bit_fall && cap_win && rx_idx_ff == `VDF_BIT_IDX_LAST))
    else $error("voice word completed off a falling edge");
  data_bit_a: assert property ($changed(DATA_BIT_OUT) |-> $past(sync_rise))
    else $error("data bit moved off the sync rising edge");
  rx_inverse_a: assert property (role_slave && $stable(role_slave) |=> SLAVE_RECEIVE_SYNC == !SLAVE_TRANSMIT_SYNC)
    else $error("receive sync is not the inverse of transmit");
  output_select_a: assert property (data_sel_s |=> !DATA_BIT_OE)
    else $error("data output driven while deselected");
  buzzer_quiet_a: assert property (!ring_s |=> !BUZZER)
    else $error("buzzer sounding without ringing");

endmodule
`default_nettype wire

// ==== tb/vdf_loop_partner.sv ====
// far-side model: free crystal and serial voice source
`timescale 1ns/1ns
`default_nettype none
module vdf_loop_partner (
  input wire logic clk,
  input wire logic bclk,
  input wire logic win,
  input wire logic [7:0] word,
  output logic xtal,
  output logic voice
);
  logic bclk_d = 1'b0; // bit clock one cycle ago
  logic win_d = 1'b0; // window one cycle ago
  logic [2:0] idx = 3'h6; // next bit to launch
  logic xtal_q = 1'b0; // free-running crystal level
  logic voice_q = 1'b0; // serial voice line level
  // ------------------------------------------------------------
  // crystal
  // ------------------------------------------------------------
  // runs at twice nominal to keep the run short; every count is a ratio to it
  assign xtal = xtal_q;
  assign voice = voice_q;
  always #61 xtal_q = ~xtal_q;
  // msb first on rising bit clock inside the window; line wanders outside
  always @(posedge clk) begin
    bclk_d <= bclk;
    win_d <= win;
    if (win && !win_d) begin
      voice_q <= word[7];
      idx <= 3'h6;
    end else if (win && bclk && !bclk_d) begin
      voice_q <= word[idx];
      idx <= idx - 3'h1;
    end else if (!win) begin
      voice_q <= ~voice_q;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the voice/data frame timing block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import vdf_pkg::*;
  logic clk = 1'b0; // core clock
  logic rst_n = 1'b0; // bench reset, active low
  vdf_role_type role = VDF_MASTER;
  logic xtal, vin, ring = 1'b0, cod = 1'b0, dos = 1'b0, dbi = 1'b0, sbi = 1'b0;
  logic [7:0] tx_word = 8'h00, p_word = 8'h00, rx_word;
  logic tx_valid = 1'b0, txd = 1'b0, txs = 1'b0;
  logic tx_ready, xbuf, tclk, msync, tsync, rsync, dclk, cms, vout, dbo, dboe, sbo, cdo, cdoe;
  logic rx_valid, rxd, rxs, buzz, under;
  logic bclk, fsync, win, brise, xrise; // role-selected timing and crystal rise
  logic bclk_d = 1'b0, fsync_d = 1'b0, xbuf_d = 1'b0;
  int fail_count = 0, tests_run = 0;
  int flen = 0, hlen = 0, xlen = 0, fc = 0, hc = 0, xc = 0; // measured lengths
  int rx_n = 0, rx_mark = 0; // received word pulses seen, and their count at frame start
  logic [7:0] q[$]; // words the fifo accepted
  logic [31:0] seed;
  // ------------------------------------------------------------
  // clock, design and far side
  // ------------------------------------------------------------
  always #5 clk = ~clk;
  assign bclk = (role == VDF_SLAVE) ? dclk : tclk;
  assign fsync = (role == VDF_SLAVE) ? tsync : msync;
  assign win = (role == VDF_SLAVE) ? rsync : msync;
  assign brise = bclk && !bclk_d;
  assign xrise = xbuf && !xbuf_d;
  vdf_frame_timing i_dut (.CORE_CLK(clk), .RESETN(rst_n), .ROLE(role), .XTAL_IN(xtal), .RING_ACTIVE(ring),
    .CONV_OUT_DISABLE(cod), .DATA_OUT_SELECT(dos), .VOICE_IN(vin), .DATA_BIT_IN(dbi), .SIG_BIT_IN(sbi),
    .TX_WORD(tx_word), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA_BIT(txd), .TX_SIG_BIT(txs),
    .XTAL_BUF(xbuf), .TRANSPORT_CLK(tclk), .MASTER_FRAME_SYNC(msync), .SLAVE_TRANSMIT_SYNC(tsync),
    .SLAVE_RECEIVE_SYNC(rsync), .DATA_CLK(dclk), .CLOCK_MODE_SELECT(cms), .VOICE_OUT(vout),
    .DATA_BIT_OUT(dbo), .DATA_BIT_OE(dboe), .SIG_BIT_OUT(sbo), .CONV_DATA_OUT(cdo), .CONV_DATA_OE(cdoe),
    .RX_WORD(rx_word), .RX_VALID(rx_valid), .RX_DATA_BIT(rxd), .RX_SIG_BIT(rxs), .BUZZER(buzz),
    .UNDERRUN(under));
  vdf_loop_partner i_far (.clk(clk), .bclk(bclk), .win(win), .word(p_word), .xtal(xtal), .voice(vin));
  // counts crystal edges per bit clock, bit clocks per frame and per window
  always @(posedge clk) begin
    bclk_d <= bclk;
    fsync_d <= fsync;
    xbuf_d <= xbuf;
    rx_n <= rx_n + int'(rx_valid);
    xc <= brise ? int'(xrise) : xc + int'(xrise);
    if (brise) xlen <= xc;
    fc <= (fsync && !fsync_d) ? int'(brise) : fc + int'(brise);
    if (fsync && !fsync_d) flen <= fc;
    hc <= fsync ? hc + int'(brise) : 0;
    if (!fsync && fsync_d) hlen <= hc;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return fsync;
      1: return bclk;
      default: return rx_n != rx_mark;
    endcase
  endfunction
  // bounded wait for a level; running out counts as a mismatch
  task automatic wait_lvl(input int s, input logic lvl, input int lim);
    int n;
    n = 0;
    while (pick(s) !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (pick(s) !== lvl) check(32'h0, 32'h1);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one frame: voice out, voice in, loose bits and lengths
  task automatic frame(input logic [7:0] exp, input logic und, input logic chk_len);
    logic [7:0] pw;
    logic d, s, td, ts, slv;
    pw = 8'($urandom);
    d = 1'($urandom);
    s = 1'($urandom);
    td = 1'($urandom);
    ts = 1'($urandom);
    slv = (role == VDF_SLAVE);
    rx_mark = rx_n;
    p_word <= pw;
    dbi <= d;
    sbi <= s;
    txd <= td;
    txs <= ts;
    wait_lvl(0, 1'b1, 8000);
    for (int i = 0; i < 8; i++) begin
      wait_lvl(1, 1'b1, 400);
      wait_lvl(1, 1'b0, 400);
      check(vout, exp[7 - i]);
      if (i == 0) check(under, und);
    end
    wait_lvl(2, 1'b1, 5000);
    check(rx_word, pw);
    if (slv) check(rsync, !tsync);
    wait_lvl(0, 1'b0, 400);
    repeat (4) @(posedge clk);
    check(dbo, td);
    check(sbo, ts);
    check(rxd, d);
    check(rxs, s);
    check(cdo, d);
    check(cms, 1'b0);
    check(hlen, 8);
    if (slv) check(msync, 1'b0);
    else check(buzz, 1'b0);
    if (chk_len) check(flen, slv ? 16 : 256);
    if (chk_len) check(xlen, slv ? 32 : 2);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = $urandom(32'hba9470fe);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      cod <= 1'($urandom);
      dos <= 1'($urandom);
      repeat (5) @(posedge clk);
      check(cdoe, !cod);
      check(dboe, !dos);
    end
    wait_lvl(0, 1'b1, 8000);
    wait_lvl(0, 1'b0, 400);
    // fill the fifo back to back past full; extra words are refused
    tx_valid <= 1'b1;
    tx_word <= 8'($urandom);
    repeat (10) begin
      @(posedge clk);
      if (tx_valid && tx_ready) q.push_back(tx_word);
      tx_word <= 8'($urandom);
    end
    tx_valid <= 1'b0;
    check(q.size(), 8);
    check(tx_ready, 1'b0);
    // drain one word a frame, then an empty fifo sends zeros
    for (int f = 0; f < 9; f++) begin
      ring <= 1'($urandom);
      frame(f < 8 ? q[f] : 8'h00, f == 8, f > 0);
    end
    rst_n <= 1'b0;
    role <= VDF_SLAVE;
    ring <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    wait_lvl(0, 1'b0, 8000);
    for (int f = 0; f < 2; f++) frame(8'h00, 1'b1, f > 0);
    wrap_up();
  end
  // watchdog sized from about fourteen frames
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
